//--- rtl/adcsq_ctrl.sv
// converter sequence control: ahb-lite registers, trigger, sequencer, results
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adcsq_ctrl #(
  parameter int SEQ_W = 4
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [11:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       channel_seven_input,
  output adcsq_pkg::adcsq_conv_req_t      conv_req,
  input  wire adcsq_pkg::adcsq_conv_rsp_t conv_rsp,
  output logic                            conv_clock,
  output logic      [7:0]                 input_buffer_mask
);
  import adcsq_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        wr_pend;
  logic [7:0]  wr_idx;
  wire         addr_ok   = hsel && hready && htrans[1];
  wire  [7:0]  addr_idx  = haddr[9:2];
  wire         do_write  = wr_pend;
  wire  [7:0]  wd        = hwdata[7:0];
  wire         rd_phase  = addr_ok && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_idx  <= addr_idx;
    end
  end

  // zero wait states: a write lands at the end of its data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] trig_reg, seq_reg, res_reg, chan_reg, testl_reg;
  logic       self_reset;
  wire  w_trig  = do_write && wr_idx == ADCSQ_OFF_TRIG;
  wire  w_seq   = do_write && wr_idx == ADCSQ_OFF_SEQ;
  wire  w_res   = do_write && wr_idx == ADCSQ_OFF_RES;
  wire  w_chan  = do_write && wr_idx == ADCSQ_OFF_CHAN;
  wire  w_stat  = do_write && wr_idx == ADCSQ_OFF_STAT;
  wire  w_testl = do_write && wr_idx == ADCSQ_OFF_TESTL;
  wire  w_inbuf = do_write && wr_idx == ADCSQ_OFF_INBUF;
  wire  w_ccf   = do_write && wr_idx == ADCSQ_OFF_CCF;

  wire       ext_trigger_enable     = trig_reg[2];
  wire       ext_trigger_polarity   = trig_reg[3];
  wire       ext_trigger_level_edge = trig_reg[4];
  wire [3:0] seq_len_field          = seq_reg[6:3];
  wire       fifo_mode              = seq_reg[2];
  wire       low_resolution_select  = res_reg[7];
  wire [4:0] prescale_field         = res_reg[4:0];
  wire       justify_mode           = chan_reg[7];
  wire       result_sign_mode       = chan_reg[6];
  wire       multi_channel_mode     = chan_reg[4];
  wire [2:0] chan_sel               = chan_reg[2:0];
  wire       special_channel_mode   = testl_reg[0];
  // zero length stands for a full sequence of eight
  wire [3:0] seq_len = (seq_len_field == 4'h0) ? 4'h8 : seq_len_field;

  // self reset clears control registers, flags and sequencer (not the buffer mask, results or clock divider) on the cycle after the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      self_reset <= 1'b0;
    end else begin
      self_reset <= w_testl && wd[2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_reg          <= ADCSQ_RST_TRIG;
      seq_reg           <= ADCSQ_RST_SEQ;
      res_reg           <= ADCSQ_RST_RES;
      chan_reg          <= ADCSQ_RST_CHAN;
      testl_reg         <= ADCSQ_RST_TESTL;
      input_buffer_mask <= 8'h00;
    end else if (self_reset) begin
      trig_reg  <= ADCSQ_RST_TRIG;
      seq_reg   <= ADCSQ_RST_SEQ;
      res_reg   <= ADCSQ_RST_RES;
      chan_reg  <= ADCSQ_RST_CHAN;
      testl_reg <= ADCSQ_RST_TESTL;
    end else begin
      if (w_trig)  trig_reg  <= {wd[7:2], 2'b00};
      if (w_seq)   seq_reg   <= {1'b0, wd[6:0]};
      if (w_res)   res_reg   <= wd;
      if (w_chan)  chan_reg  <= {wd[7:4], 1'b0, wd[2:0]};
      if (w_testl) testl_reg <= {testl_reg[7:6], 5'b0, wd[0]};
      if (w_inbuf) input_buffer_mask <= wd;
    end
  end

  // ----------------------------------------------------------------
  // conversion clock: prescale then divide by two
  // ----------------------------------------------------------------
  logic [4:0] pre_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt    <= 5'h00;
      conv_clock <= 1'b0;
    end else if (pre_cnt >= prescale_field) begin
      pre_cnt    <= 5'h00;
      conv_clock <= ~conv_clock;
    end else begin
      pre_cnt <= pre_cnt + 5'd1;
    end
  end

  // ----------------------------------------------------------------
  // external trigger from the channel seven pin
  // ----------------------------------------------------------------
  logic trig_s1, trig_s2, trig_s3;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= channel_seven_input;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end
  wire trig_lvl  = trig_s2 ^ ~ext_trigger_polarity;
  wire trig_prev = trig_s3 ^ ~ext_trigger_polarity;
  wire trig_edge = trig_lvl && !trig_prev;
  wire trig_fire = ext_trigger_enable &&
                   (ext_trigger_level_edge ? trig_lvl : trig_edge);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  adcsq_state_t state;
  logic [3:0]   conv_done_cnt;
  logic [2:0]   cur_chan;
  logic [2:0]   next_slot;
  logic [7:0]   ccf;
  logic         seq_complete_flag, trigger_overrun_flag, result_overrun_flag;
  logic [15:0]  result_mem [ADCSQ_NRES];

  wire sw_start  = w_chan && !ext_trigger_enable;
  wire start     = (state == ADCSQ_IDLE) && (sw_start || trig_fire);
  wire busy      = state != ADCSQ_IDLE;
  wire conv_done = (state == ADCSQ_CONV) && conv_rsp.done;
  wire last_conv = conv_done && (conv_done_cnt + 4'd1 == seq_len);
  // a software start takes the channel code written in that same cycle
  wire [2:0] start_chan = w_chan ? wd[2:0] : chan_sel;

  // ----------------------------------------------------------------
  // result formatting
  // ----------------------------------------------------------------
  wire [9:0]  raw10 = low_resolution_select ? {2'b00, conv_rsp.value[9:2]}
                                            : conv_rsp.value;
  wire [9:0]  sgn10 = low_resolution_select ? {2'b00, ~raw10[7], raw10[6:0]}
                                            : {~raw10[9], raw10[8:0]};
  wire [9:0]  fmt10 = result_sign_mode ? sgn10 : raw10;
  wire [15:0] right_j = low_resolution_select ?
                 {{8{result_sign_mode & fmt10[7]}}, fmt10[7:0]} :
                 {{6{result_sign_mode & fmt10[9]}}, fmt10};
  wire [15:0] left_j  = low_resolution_select ? {fmt10[7:0], 8'h00}
                                              : {fmt10, 6'b00_0000};
  wire [15:0] result_word = justify_mode ? right_j : left_j;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state         <= ADCSQ_IDLE;
      conv_done_cnt <= 4'h0;
      cur_chan      <= 3'h0;
      next_slot     <= 3'h0;
    end else if (self_reset) begin
      state     <= ADCSQ_IDLE;
      next_slot <= 3'h0;
    end else begin
      unique case (state)
        ADCSQ_IDLE: begin
          if (start) begin
            state         <= ADCSQ_CONV;
            conv_done_cnt <= 4'h0;
            cur_chan      <= start_chan;
            if (!fifo_mode) next_slot <= 3'h0;
          end
        end
        ADCSQ_CONV: begin
          if (conv_done) begin
            next_slot     <= next_slot + 3'd1;
            conv_done_cnt <= conv_done_cnt + 4'd1;
            if (multi_channel_mode) cur_chan <= cur_chan + 3'd1;
            state <= last_conv ? ADCSQ_IDLE : ADCSQ_WAIT;
          end
        end
        ADCSQ_WAIT: state <= ADCSQ_CONV;
        default:    state <= ADCSQ_IDLE;
      endcase
    end
  end

  assign conv_req.go      = state == ADCSQ_CONV;
  assign conv_req.chan    = cur_chan;
  assign conv_req.special = special_channel_mode;
  assign conv_req.low_res = low_resolution_select;

  // ----------------------------------------------------------------
  // results and flags; a hardware set wins over a software clear
  // ----------------------------------------------------------------
  wire [7:0] slot_hit = conv_done ? (8'h01 << next_slot) : 8'h00;

  // no reset on result storage: a slot reads unknown until first written
  always_ff @(posedge hclk) begin
    for (int i = 0; i < ADCSQ_NRES; i++) begin
      if (slot_hit[i]) result_mem[i] <= result_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ccf                  <= 8'h00;
      seq_complete_flag    <= 1'b0;
      trigger_overrun_flag <= 1'b0;
      result_overrun_flag  <= 1'b0;
    end else if (self_reset) begin
      ccf                  <= 8'h00;
      seq_complete_flag    <= 1'b0;
      trigger_overrun_flag <= 1'b0;
      result_overrun_flag  <= 1'b0;
    end else begin
      ccf <= (ccf & ~(w_ccf ? wd : 8'h00)) | slot_hit;
      seq_complete_flag <= last_conv ||
                           (seq_complete_flag && !(w_stat && wd[7]));
      trigger_overrun_flag <= (busy && ext_trigger_enable && !ext_trigger_level_edge
                               && trig_edge) ||
                              (trigger_overrun_flag && !(w_stat && wd[5]));
      result_overrun_flag <= (|(slot_hit & ccf)) ||
                             (result_overrun_flag && !(w_stat && wd[4]));
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] stat_rd = {seq_complete_flag, 1'b0, trigger_overrun_flag,
                        result_overrun_flag, 1'b0, next_slot};
  wire [7:0] testl_rd = {testl_reg[7:6], 3'b000, 1'b0,
                         conv_clock, special_channel_mode};
  wire       is_res   = addr_idx[7:3] == ADCSQ_OFF_RESULT[7:3];
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (is_res) begin
      next_rdata = {16'h0000, result_mem[addr_idx[2:0]]};
    end else begin
      unique case (addr_idx)
        ADCSQ_OFF_TRIG:  next_rdata[7:0] = trig_reg;
        ADCSQ_OFF_SEQ:   next_rdata[7:0] = seq_reg;
        ADCSQ_OFF_RES:   next_rdata[7:0] = res_reg;
        ADCSQ_OFF_CHAN:  next_rdata[7:0] = chan_reg;
        ADCSQ_OFF_STAT:  next_rdata[7:0] = stat_rd;
        ADCSQ_OFF_TESTH: next_rdata[7:0] = ADCSQ_RST_TESTH;
        ADCSQ_OFF_TESTL: next_rdata[7:0] = testl_rd;
        ADCSQ_OFF_CCF:   next_rdata[7:0] = ccf;
        ADCSQ_OFF_INBUF: next_rdata[7:0] = input_buffer_mask;
        default:         next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_phase) begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  seq_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    last_conv && !self_reset |=> seq_complete_flag && state == ADCSQ_IDLE)
    else $error("sequence complete flag not set after last result");
  res_ovr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done && ccf[next_slot] && !self_reset |=> result_overrun_flag)
    else $error("result overrun not flagged");
  trig_ovr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    busy && ext_trigger_enable && !ext_trigger_level_edge && trig_edge && !self_reset
    |=> trigger_overrun_flag)
    else $error("trigger overrun not flagged");
  slot_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done && next_slot == 3'd7 && !self_reset |=> next_slot == 3'd0)
    else $error("result slot did not wrap");
  fixed_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start && !fifo_mode && !self_reset |=> next_slot == 3'd0)
    else $error("fixed mode sequence not started at first slot");
  multi_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done && multi_channel_mode && !self_reset |=> cur_chan == $past(cur_chan) + 3'd1)
    else $error("multi channel scan did not advance");
  first_chan_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start && !self_reset |=> conv_req.chan == chan_sel && conv_req.go)
    else $error("sequence did not start at selected channel");
  self_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
    w_testl && wd[2] |=> ##1 state == ADCSQ_IDLE && seq_reg == ADCSQ_RST_SEQ)
    else $error("self reset did not restore state");
  trig_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == ADCSQ_IDLE && !ext_trigger_enable && !w_chan |=> state == ADCSQ_IDLE)
    else $error("sequence started without a trigger");
  done_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done && !self_reset |=> ccf[$past(next_slot)])
    else $error("conversion complete flag not set for written slot");
  result_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done && !self_reset |=> result_mem[$past(next_slot)] == $past(result_word))
    else $error("result not stored in the addressed slot");
  level_fire_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == ADCSQ_IDLE && ext_trigger_enable && ext_trigger_level_edge && trig_lvl
    && !self_reset |=> conv_req.go)
    else $error("active trigger level did not start a sequence");
  single_chan_a: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done && !multi_channel_mode && !self_reset |=> $stable(cur_chan))
    else $error("single channel mode changed the channel");
  seq_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    last_conv && !self_reset |=> conv_done_cnt == $past(seq_len))
    else $error("sequence ended after the wrong number of results");
  stat_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    w_stat && wd[7] && !last_conv && !self_reset |=> !seq_complete_flag)
    else $error("sequence complete flag not cleared by software");

endmodule : adcsq_ctrl
`default_nettype wire

//--- rtl/adcsq_pkg.sv
// constants, types and register map of the converter sequence control block
// Summary of operation
// - eight multiplexed channels, ten-bit successive approximation
// - external trigger: enable, polarity, edge or level
// - trigger input taken from channel seven pin
// - sequence length from four-bit field
// - reset: length four, fifo mode off
// - fifo off: results fill registers from first
// - fifo on: registers continue and wrap around
// - justification bit places result by resolution
// - sign bit selects signed or unsigned result
// - reset gives unsigned left justified results
// - channel code: single channel or first
// - multi mode scans length successive channels
// - resolution bit selects eight or ten
// - reset prescale six, further divided by two
// - external trigger disabled after reset
// - extra edges during sequence set overrun in edge-triggered mode only
// - overwriting result whose complete flag is still set sets overrun flag
// - self reset bit resets control registers, flags and sequencer, not the buffer mask
// - special channel bit selects internal sources
// - test bit shows conversion clock state
// - per pin digital input buffer enable
// - eight result registers hold results
package adcsq_pkg;

  localparam logic [7:0] ADCSQ_OFF_TRIG   = 8'h02;
  localparam logic [7:0] ADCSQ_OFF_SEQ    = 8'h03;
  localparam logic [7:0] ADCSQ_OFF_RES    = 8'h04;
  localparam logic [7:0] ADCSQ_OFF_CHAN   = 8'h05;
  localparam logic [7:0] ADCSQ_OFF_STAT   = 8'h06;
  localparam logic [7:0] ADCSQ_OFF_TESTH  = 8'h08;
  localparam logic [7:0] ADCSQ_OFF_TESTL  = 8'h09;
  localparam logic [7:0] ADCSQ_OFF_INBUF  = 8'h0D;
  localparam logic [7:0] ADCSQ_OFF_CCF    = 8'h0B;
  localparam logic [7:0] ADCSQ_OFF_RESULT = 8'h10;

  localparam logic [7:0] ADCSQ_RST_TRIG  = 8'h00;
  localparam logic [7:0] ADCSQ_RST_SEQ   = 8'h20;
  localparam logic [7:0] ADCSQ_RST_RES   = 8'h05;
  localparam logic [7:0] ADCSQ_RST_CHAN  = 8'h00;
  localparam logic [7:0] ADCSQ_RST_TESTH = 8'h80;
  localparam logic [7:0] ADCSQ_RST_TESTL = 8'h80;

  localparam int ADCSQ_NCHAN = 8;
  localparam int ADCSQ_NRES  = 8;

  typedef struct packed {
    logic       go;
    logic [2:0] chan;
    logic       special;
    logic       low_res;
  } adcsq_conv_req_t;

  typedef struct packed {
    logic       done;
    logic [9:0] value;
  } adcsq_conv_rsp_t;

  typedef enum logic [2:0] {
    ADCSQ_IDLE = 3'b001,
    ADCSQ_CONV = 3'b010,
    ADCSQ_WAIT = 3'b100
  } adcsq_state_t;

endpackage : adcsq_pkg

//--- tb/adcsq_core_model.sv
// stand-in for the analog converter core that answers conversion requests
`timescale 1ns/1ps
`default_nettype none
module adcsq_core_model #(
  parameter int DLY = 20
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire adcsq_pkg::adcsq_conv_req_t req,
  output adcsq_pkg::adcsq_conv_rsp_t      rsp,
  output logic                            last_sp,
  output logic [7:0]                      count
);
  import adcsq_pkg::*;
  logic [7:0] cnt;
  logic       hold;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 8'h00;
      hold    <= 1'b0;
      rsp     <= '0;
      last_sp <= 1'b0;
      count   <= 8'h00;
    end else begin
      rsp.done <= 1'b0;
      // outside a result the data lines never repeat the last value
      rsp.value <= ~rsp.value;
      if (!req.go) begin
        hold <= 1'b0;
        cnt  <= 8'h00;
      end else if (!hold && cnt == DLY[7:0]) begin
        rsp.done  <= 1'b1;
        rsp.value <= {req.chan, req.special, 6'h2D};
        hold      <= 1'b1;
        count     <= count + 8'h01;
        last_sp   <= req.special;
      end else if (!hold) begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule : adcsq_core_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the converter sequence control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adcsq_pkg::*;
  logic            hclk, hresetn, hsel, hwrite, ch7, hresp, conv_clock, last_sp;
  logic [11:0]     haddr;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [31:0]     hwdata, hrdata, q;
  logic            hreadyout;
  wire logic       hready;
  logic [7:0]      mask, count;
  adcsq_conv_req_t conv_req;
  adcsq_conv_rsp_t conv_rsp;
  int              miscompares, check_count;
  assign hready = hreadyout;
  adcsq_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .channel_seven_input(ch7),
    .conv_req(conv_req), .conv_rsp(conv_rsp), .conv_clock(conv_clock),
    .input_buffer_mask(mask));
  adcsq_core_model core (.clk(hclk), .rst_n(hresetn), .req(conv_req), .rsp(conv_rsp),
    .last_sp(last_sp), .count(count));
  always #2.5 hclk = ~hclk;
  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      miscompares++;
      end_sim;
    end
  endtask : rdy
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    rdy;
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h00_0000, d});
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [15:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk({16'h0000, q[15:0]}, {16'h0000, e});
  endtask : rchk
  // polls status until the sequence complete flag shows, q keeps the status
  task automatic wdone;
    int n;
    n = 0;
    do begin
      xfer(1'b0, 12'h018, 32'h0000_0000);
      n++;
    end while (q[7] !== 1'b1 && n < 200);
    if (q[7] !== 1'b1) begin
      miscompares++;
      end_sim;
    end
  endtask : wdone
  task automatic clr;
    wr(12'h018, 8'hFF);
    wr(12'h02C, 8'hFF);
  endtask : clr
  function automatic logic [9:0] cv(input logic [2:0] c, input logic s);
    return {c, s, 6'h2D};
  endfunction : cv
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    int n, k;
    logic p;
    rchk(12'h008, 16'h0000);
    rchk(12'h00C, 16'h0020);
    rchk(12'h010, 16'h0005);
    rchk(12'h014, 16'h0000);
    rchk(12'h018, 16'h0000);
    rchk(12'h020, 16'h0080);
    rchk(12'h03C, 16'h0000);
    xfer(1'b0, 12'h024, 32'h0000_0000);
    chk(q & 32'h0000_FFFD, 32'h0000_0080);
    p = conv_clock;
    n = 0;
    k = 0;
    repeat (40) begin
      @(posedge hclk);
      if (conv_clock && !p) begin
        if (k > 0) chk(n, 12);
        k++;
        n = 0;
      end
      n++;
      p = conv_clock;
    end
    chk(k > 1, 1);
  endtask : t_reset
  task automatic t_single;
    wr(12'h00C, 8'h08);
    wr(12'h014, 8'h03);
    wdone;
    rchk(12'h040, {cv(3'd3, 1'b0), 6'h00});
    // only status flags cleared: slot 0 stays marked for the overrun case
    wr(12'h018, 8'hFF);
  endtask : t_single
  task automatic t_multi;
    wr(12'h00C, 8'h20);
    wr(12'h014, 8'h96);
    wdone;
    chk(q[4], 1'b1);
    for (int n = 0; n < 4; n++) begin
      rchk(12'h040 + 12'(4 * n), {6'h00, cv(3'(6 + n), 1'b0)});
    end
    clr;
  endtask : t_multi
  task automatic t_fifo;
    wr(12'h00C, 8'h34);
    wr(12'h024, 8'h04);
    // the self reset acts one cycle after its write lands
    @(posedge hclk);
    rchk(12'h00C, 16'h0020);
    rchk(12'h014, 16'h0000);
    wr(12'h00C, 8'h34);
    wr(12'h014, 8'h10);
    wdone;
    clr;
    wr(12'h00C, 8'h24);
    wr(12'h014, 8'h14);
    wdone;
    chk(q[2:0], 3'd2);
    chk(q[4], 1'b0);
    rchk(12'h05C, {cv(3'd5, 1'b0), 6'h00});
    rchk(12'h040, {cv(3'd6, 1'b0), 6'h00});
    clr;
    wr(12'h00C, 8'h08);
  endtask : t_fifo
  task automatic t_fmt;
    logic [9:0] v;
    v = cv(3'd2, 1'b1);
    wr(12'h010, 8'h85);
    wr(12'h024, 8'h01);
    wr(12'h014, 8'h42);
    wdone;
    chk(last_sp, 1'b1);
    rchk(12'h040, {v[9:2] ^ 8'h80, 8'h00});
    wr(12'h024, 8'h00);
    wr(12'h010, 8'h05);
    clr;
  endtask : t_fmt
  task automatic t_trig;
    logic [7:0] c;
    wr(12'h008, 8'h0C);
    wr(12'h014, 8'h05);
    c = count;
    repeat (10) @(posedge hclk);
    chk(count, c);
    ch7 <= 1'b1;
    repeat (12) @(posedge hclk);
    ch7 <= 1'b0;
    repeat (3) @(posedge hclk);
    ch7 <= 1'b1;
    wdone;
    chk(q[5], 1'b1);
    chk(count != c, 1'b1);
    ch7 <= 1'b0;
    wr(12'h008, 8'h00);
    clr;
    wr(12'h008, 8'h1C);
    c = count;
    repeat (10) @(posedge hclk);
    chk(count, c);
    ch7 <= 1'b1;
    wdone;
    ch7 <= 1'b0;
    chk(count != c, 1'b1);
    wr(12'h008, 8'h00);
    repeat (40) @(posedge hclk);
    clr;
  endtask : t_trig
  task automatic t_mask;
    wr(12'h034, 8'hA5);
    @(posedge hclk);
    chk(mask, 8'hA5);
    rchk(12'h034, 16'h00A5);
  endtask : t_mask
  initial begin
    hclk        = 1'b0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 12'h000;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'b010;
    hwdata      = 32'h0000_0000;
    ch7         = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_single;
    t_multi;
    t_fifo;
    t_fmt;
    t_trig;
    t_mask;
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
